// *** design/symseq_pkg.sv ***
package symseq_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_MHZ       = 200;
  localparam int UST_US        = 100;
  localparam int UST_CYCLES    = UST_US * CLK_MHZ;
  localparam int TS_TICK_NS    = 279;
  localparam int TS_CYCLES     = TS_TICK_NS / CLK_PERIOD_NS;
  localparam int RUNAWAY_SYMS  = 1000;
  localparam int CHECK_BITS    = 16;
  localparam int STAMP_BYTES   = 4;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_REQUEST = 8'h00;
  localparam logic [7:0] ADDR_CONFIRM = 8'h04;
  localparam logic [7:0] ADDR_TXBUF   = 8'h08;
  localparam logic [7:0] ADDR_RXBUF   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;

  // Host request register fields
  localparam int REQ_TX      = 7;
  localparam int REQ_STOP_RX = 5;
  localparam int REQ_LZS     = 4;
  localparam int REQ_RESTART = 3;
  localparam int REQ_DEL_LO  = 1;
  localparam int REQ_STAMP   = 0;
  localparam logic [7:0] REQ_START_MASK = 8'hEF;
  localparam logic [7:0] REQ_START_VAL  = 8'hA6;
  localparam logic [7:0] REQ_BODY_MASK  = 8'hE9;
  localparam logic [7:0] REQ_BODY_VAL   = 8'hA0;
  localparam logic [7:0] REQ_TX_NEXT    = 8'hA1;
  localparam logic [7:0] REQ_RX_NEXT    = 8'h01;

  // Delimiter select codes
  localparam logic [1:0] DEL_NONE = 2'h0;
  localparam logic [1:0] DEL_EOF  = 2'h1;
  localparam logic [1:0] DEL_EOP  = 2'h2;
  localparam logic [3:0] LEN_EOF  = 4'h3;
  localparam logic [3:0] LEN_EOP  = 4'h4;
  localparam logic [3:0] LEN_PREAMBLE_END_DELIMITER = 4'h8;

  // Device confirm codes
  localparam logic [7:0] CNF_QUIET     = 8'h00;
  localparam logic [7:0] CNF_ACTIVE    = 8'h80;
  localparam logic [7:0] CNF_LOST      = 8'h60;
  localparam logic [7:0] CNF_COLLIDE   = 8'hA0;
  localparam logic [7:0] CNF_BUF_EMPTY = 8'h10;
  localparam logic [7:0] CNF_STAMP     = 8'hB4;
  localparam logic [7:0] CNF_RUNAWAY   = 8'h01;
  localparam int         CNF_GOOD      = 3;

  // Medium states
  localparam logic [1:0] MED_INF  = 2'h0;
  localparam logic [1:0] MED_SUP1 = 2'h1;
  localparam logic [1:0] MED_SUP2 = 2'h2;

  localparam logic [15:0] CRC_INIT = 16'h0000;

  typedef enum logic [8:0] {
    ST_INIT     = 9'h001,
    ST_IDLE     = 9'h002,
    ST_RX_PRE   = 9'h004,
    ST_RX_CHECK = 9'h008,
    ST_RX_STAMP = 9'h010,
    ST_TX_PRE   = 9'h020,
    ST_TX_BODY  = 9'h040,
    ST_TX_CHECK = 9'h080,
    ST_TX_STAMP = 9'h100
  } seq_state_t;

  typedef struct packed {
    seq_state_t  state;
    logic [15:0] ust_cnt;
    logic [7:0]  ts_div;
    logic [31:0] ts;
    logic [31:0] stamp;
    logic [1:0]  byte_idx;
    logic [7:0]  req;
    logic [7:0]  txbuf;
    logic [7:0]  rxbuf;
    logic [7:0]  conf;
    logic        pend;
    logic        due;
    logic [7:0]  due_code;
    logic [7:0]  lfsr;
    logic        pkt_sup2;
    logic [1:0]  med;
    logic        tx_en;
    logic        pre_inf;
    logic [3:0]  sym_left;
    logic [7:0]  bits;
    logic [3:0]  nbits;
    logic [1:0]  del;
    logic        eop_sent;
    logic        hold_v;
    logic [7:0]  hold_byte;
    logic        hold_lzs;
    logic [1:0]  hold_del;
    logic [15:0] crc;
    logic [4:0]  chk_cnt;
    logic [9:0]  sup_run;
    logic        runaway;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } seq_regs_t;

endpackage

// *** design/powerline_symbol_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none

// Function
// - Check phase ends to timestamp, or idle
// - Receive timestamp: four bytes, low first
// - Leave receive timestamp on abort, stamp clear
// - Send 8-bit preamble, seed then pseudo-random
// - Preamble alternates superior and inferior
// - Preamble end: superior for 8 USTs
// - Zero suppress skips preamble, generator advances
// - Packet superior alternates, first is superior 2
// - Activity at inferior preamble means collision
// - Cleared transmit bit aborts to idle
// - Body bits LSB first, 1/2 UNIT_SYMBOL_TIME
// - Zero suppress drops leading zero bits
// - Delimiter select: none, field or packet end
// - Handshake once byte copied to holding in the body; for a copy during the preamble, at body start
// - After packet end, go to check
// - Send 16 check bits MSB first, then one zero symbol
// - Check done: handshake, timestamp, stamp state
// - Transmit timestamp four bytes, 275ns tick
// - Zero request leaves transmit timestamp
// - No new handshake before confirm read
// - Preamble-end confirm pattern with flags
// - Runaway flag after 1000 superior symbols
// - Delimiter codes 00, 01, 10
// - Soft restart returns to initialization
// - Free-running 32-bit timestamp counter
module powerline_symbol_sequencer #(
  parameter int          UST_CYC  = symseq_pkg::UST_CYCLES,
  parameter logic [15:0] CRC_POLY = 16'h8005
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [1:0]  rx_med_i,
  input  wire logic        line_active_i,
  input  wire logic        rx_body_end_i,
  input  wire logic [15:0] rx_crc_i,
  input  wire logic        rx_preamble_end_delimiter_i,
  input  wire logic        rx_preamble_end_delimiter_noise_i,
  input  wire logic        rx_pre_data_i,
  input  wire logic [7:0]  rx_pre_byte_i,
  output logic      [1:0]  tx_med_o,
  output logic             tx_en_o,
  output logic             hs_int_o
);

  if (UST_CYC < 16 || UST_CYC > 65535)
  begin : g_bad_ust
    $error("UST_CYC out of range");
  end

  symseq_pkg::seq_regs_t r_r;
  symseq_pkg::seq_regs_t r_nxt;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic        b);
    logic fb;
    fb = c[15] ^ b;
    crc_step = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
  endfunction

  // Number of bits up to and including the highest one
  function automatic logic [3:0] sig_len(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (v[i])
        n = 4'(i + 1);
    end
    sig_len = n;
  endfunction

  function automatic logic [1:0] other_sup(input logic [1:0] m);
    other_sup = (m == symseq_pkg::MED_SUP1) ? symseq_pkg::MED_SUP2
                                            : symseq_pkg::MED_SUP1;
  endfunction

  logic       unit_symbol_time;
  logic       apb_done;
  logic       wr;
  logic       rd;
  logic [7:0] wbyte;
  logic [1:0] pkt_sup;
  logic       sym_end;

  assign unit_symbol_time      = (r_r.ust_cnt == 16'h0000);
  assign apb_done = psel_i & penable_i & r_r.pready;
  assign wr       = apb_done & pwrite_i & ~r_r.pslverr;
  assign rd       = apb_done & ~pwrite_i;
  assign wbyte    = pwdata_i[7:0];
  assign pkt_sup  = r_r.pkt_sup2 ? symseq_pkg::MED_SUP2
                                 : symseq_pkg::MED_SUP1;
  assign sym_end  = unit_symbol_time & (r_r.sym_left == 4'h1);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic       req_wr;
    logic       txb_wr;
    logic       mapped;
    logic [7:0] rdv;
    r_nxt  = r_r;
    rdv    = 8'h00;
    req_wr = wr & (paddr_i == symseq_pkg::ADDR_REQUEST);
    txb_wr = wr & (paddr_i == symseq_pkg::ADDR_TXBUF);
    mapped = (paddr_i == symseq_pkg::ADDR_REQUEST)
           | (paddr_i == symseq_pkg::ADDR_CONFIRM)
           | (paddr_i == symseq_pkg::ADDR_TXBUF)
           | (paddr_i == symseq_pkg::ADDR_RXBUF)
           | (paddr_i == symseq_pkg::ADDR_STATUS);

    // Bus slave: one wait state, answer in the second access cycle
    r_nxt.pready  = psel_i & penable_i & ~r_r.pready;
    r_nxt.pslverr = psel_i & penable_i & ~r_r.pready & ~mapped;
    case (paddr_i)
      symseq_pkg::ADDR_REQUEST: rdv = r_r.req;
      symseq_pkg::ADDR_CONFIRM: rdv = r_r.conf;
      symseq_pkg::ADDR_TXBUF:   rdv = r_r.txbuf;
      symseq_pkg::ADDR_RXBUF:   rdv = r_r.rxbuf;
      default:                  rdv = 8'h00;
    endcase
    if (psel_i & penable_i & ~r_r.pready)
    begin
      if (paddr_i == symseq_pkg::ADDR_STATUS)
        r_nxt.prdata = {21'h000000, r_r.hold_v, 1'b0, r_r.state};
      else
        r_nxt.prdata = {24'h000000, rdv};
    end
    if (req_wr)
      r_nxt.req = wbyte;
    if (txb_wr)
      r_nxt.txbuf = wbyte;

    // Reading the confirm register acknowledges the handshake
    if (rd & (paddr_i == symseq_pkg::ADDR_CONFIRM))
      r_nxt.pend = 1'b0;

    // Timebases
    r_nxt.ust_cnt = unit_symbol_time ? 16'(UST_CYC - 1) : r_r.ust_cnt - 16'h0001;
    if (r_r.ts_div == 8'(symseq_pkg::TS_CYCLES - 1))
    begin
      r_nxt.ts_div = 8'h00;
      r_nxt.ts     = r_r.ts + 32'h00000001;
    end
    else
      r_nxt.ts_div = r_r.ts_div + 8'h01;

    // Symbol timer counts down on every UNIT_SYMBOL_TIME until it reaches zero
    if (unit_symbol_time & (r_r.sym_left != 4'h0))
      r_nxt.sym_left = r_r.sym_left - 4'h1;

    // Runaway watch over consecutive superior symbols
    if (unit_symbol_time)
    begin
      if (r_r.med != symseq_pkg::MED_INF
          || (rx_med_i != symseq_pkg::MED_INF && !r_r.tx_en))
      begin
        if (r_r.sup_run != 10'(symseq_pkg::RUNAWAY_SYMS))
          r_nxt.sup_run = r_r.sup_run + 10'h001;
        else if (!r_r.runaway && r_r.state != symseq_pkg::ST_IDLE)
        begin
          r_nxt.runaway  = 1'b1;
          r_nxt.due      = 1'b1;
          r_nxt.due_code = r_r.conf | symseq_pkg::CNF_RUNAWAY;
        end
      end
      else
        r_nxt.sup_run = 10'h000;
    end

    case (r_r.state)
      symseq_pkg::ST_INIT:
      begin
        // The preamble seed is whatever sits in the buffer on release
        if (req_wr && wbyte == 8'h00)
        begin
          r_nxt.lfsr  = r_r.txbuf;
          r_nxt.state = symseq_pkg::ST_IDLE;
        end
      end

      symseq_pkg::ST_IDLE:
      begin
        r_nxt.runaway = 1'b0;
        if (req_wr && ((wbyte & symseq_pkg::REQ_START_MASK)
                       == symseq_pkg::REQ_START_VAL))
        begin
          r_nxt.state    = symseq_pkg::ST_TX_PRE;
          r_nxt.pkt_sup2 = ~r_r.pkt_sup2;
          r_nxt.bits     = r_r.lfsr;
          r_nxt.nbits    = wbyte[symseq_pkg::REQ_LZS] ? 4'h0 : 4'h8;
          r_nxt.lfsr     = {r_r.lfsr[6:0],
                            r_r.lfsr[7] ^ r_r.lfsr[5]
                            ^ r_r.lfsr[4] ^ r_r.lfsr[3]};
          // Counts as just after an inferior: first symbol is superior,
          // and the line is sensed before anything is sent
          r_nxt.pre_inf  = 1'b1;
          r_nxt.sym_left = 4'h0;
          r_nxt.crc      = symseq_pkg::CRC_INIT;
          r_nxt.hold_v   = 1'b0;
          r_nxt.del      = symseq_pkg::DEL_NONE;
          r_nxt.eop_sent = 1'b0;
          r_nxt.due      = 1'b1;
          r_nxt.due_code = symseq_pkg::CNF_BUF_EMPTY;
        end
        else if (rx_med_i != symseq_pkg::MED_INF)
        begin
          r_nxt.state    = symseq_pkg::ST_RX_PRE;
          r_nxt.due      = 1'b1;
          r_nxt.due_code = symseq_pkg::CNF_ACTIVE;
        end
        else if (unit_symbol_time && !r_r.pend)
        begin
          r_nxt.due      = 1'b1;
          r_nxt.due_code = symseq_pkg::CNF_QUIET;
        end
      end

      symseq_pkg::ST_RX_PRE:
      begin
        if (req_wr && wbyte[symseq_pkg::REQ_STOP_RX])
          r_nxt.state = symseq_pkg::ST_IDLE;
        else if (rx_preamble_end_delimiter_i)
        begin
          // Preamble end seen by the front end
          r_nxt.rxbuf    = rx_pre_byte_i;
          r_nxt.due      = 1'b1;
          r_nxt.due_code = {1'b1, rx_preamble_end_delimiter_noise_i, 1'b1, rx_pre_data_i,
                            4'h6};
        end
        else if (rx_body_end_i)
        begin
          r_nxt.state   = symseq_pkg::ST_RX_CHECK;
          r_nxt.crc     = rx_crc_i;
          r_nxt.chk_cnt = 5'h00;
        end
      end

      symseq_pkg::ST_RX_CHECK:
      begin
        if ((req_wr && wbyte[symseq_pkg::REQ_STOP_RX])
            || (unit_symbol_time && rx_med_i == symseq_pkg::MED_INF))
        begin
          r_nxt.state = symseq_pkg::ST_IDLE;
          if (!(req_wr && wbyte[symseq_pkg::REQ_STOP_RX]))
          begin
            r_nxt.due      = 1'b1;
            r_nxt.due_code = symseq_pkg::CNF_LOST;
          end
        end
        else if (unit_symbol_time)
        begin
          r_nxt.crc     = crc_step(r_r.crc,
                                   rx_med_i == symseq_pkg::MED_SUP1);
          r_nxt.chk_cnt = r_r.chk_cnt + 5'h01;
          if (r_r.chk_cnt == 5'(symseq_pkg::CHECK_BITS - 1))
          begin
            r_nxt.state    = symseq_pkg::ST_RX_STAMP;
            r_nxt.stamp    = r_r.ts;
            r_nxt.rxbuf    = r_r.ts[7:0];
            r_nxt.byte_idx = 2'h1;
            r_nxt.due      = 1'b1;
            r_nxt.due_code = symseq_pkg::CNF_STAMP;
            r_nxt.due_code[symseq_pkg::CNF_GOOD] =
              (crc_step(r_r.crc, rx_med_i == symseq_pkg::MED_SUP1)
               == 16'h0000);
          end
        end
      end

      symseq_pkg::ST_RX_STAMP, symseq_pkg::ST_TX_STAMP:
      begin
        if (r_r.state == symseq_pkg::ST_RX_STAMP && req_wr
            && !wbyte[symseq_pkg::REQ_STAMP]
            && wbyte[symseq_pkg::REQ_STOP_RX])
          r_nxt.state = symseq_pkg::ST_IDLE;
        else if (r_r.state == symseq_pkg::ST_TX_STAMP && req_wr
                 && wbyte == 8'h00)
          r_nxt.state = symseq_pkg::ST_IDLE;
        else if (req_wr && r_r.byte_idx != 2'h0
                 && ((r_r.state == symseq_pkg::ST_RX_STAMP
                      && wbyte == symseq_pkg::REQ_RX_NEXT)
                  || (r_r.state == symseq_pkg::ST_TX_STAMP
                      && wbyte == symseq_pkg::REQ_TX_NEXT)))
        begin
          r_nxt.rxbuf    = r_r.stamp[8*r_r.byte_idx +: 8];
          r_nxt.byte_idx = r_r.byte_idx + 2'h1;
          r_nxt.due      = 1'b1;
          r_nxt.due_code = symseq_pkg::CNF_STAMP;
        end
      end

      symseq_pkg::ST_TX_PRE:
      begin
        if (req_wr && !wbyte[symseq_pkg::REQ_TX])
          r_nxt.state = symseq_pkg::ST_IDLE;
        else if (line_active_i && (!r_r.tx_en || r_r.pre_inf))
        begin
          r_nxt.state    = symseq_pkg::ST_RX_PRE;
          r_nxt.due      = 1'b1;
          r_nxt.due_code = symseq_pkg::CNF_COLLIDE;
        end
        else if (r_r.sym_left == 4'h0 || sym_end)
        begin
          if (r_r.nbits != 4'h0)
          begin
            r_nxt.pre_inf  = r_r.tx_en & ~r_r.pre_inf;
            r_nxt.sym_left = r_r.bits[0] ? 4'h1 : 4'h2;
            r_nxt.bits     = {1'b0, r_r.bits[7:1]};
            r_nxt.nbits    = r_r.nbits - 4'h1;
          end
          else if (!r_r.pre_inf && r_r.tx_en && r_r.sym_left == 4'h1
                   && r_r.med == pkt_sup && r_r.del == 2'h3)
          begin
            r_nxt.state    = symseq_pkg::ST_TX_BODY;
            r_nxt.due      = 1'b1;
            r_nxt.due_code = symseq_pkg::CNF_BUF_EMPTY;
          end
          else
          begin
            r_nxt.pre_inf  = 1'b0;
            r_nxt.sym_left = symseq_pkg::LEN_PREAMBLE_END_DELIMITER;
            r_nxt.del      = 2'h3;
          end
        end
        if (req_wr && wbyte[symseq_pkg::REQ_TX]
            && ((wbyte & symseq_pkg::REQ_BODY_MASK)
                == symseq_pkg::REQ_BODY_VAL) && !r_r.hold_v)
        begin
          r_nxt.hold_v    = 1'b1;
          r_nxt.hold_byte = r_r.txbuf;
          r_nxt.hold_lzs  = wbyte[symseq_pkg::REQ_LZS];
          r_nxt.hold_del  = wbyte[symseq_pkg::REQ_DEL_LO +: 2];
        end
      end

      symseq_pkg::ST_TX_BODY:
      begin
        if (req_wr && !wbyte[symseq_pkg::REQ_TX])
          r_nxt.state = symseq_pkg::ST_IDLE;
        else
        begin
          if (req_wr && ((wbyte & symseq_pkg::REQ_BODY_MASK)
                         == symseq_pkg::REQ_BODY_VAL) && !r_r.hold_v)
          begin
            r_nxt.hold_v    = 1'b1;
            r_nxt.hold_byte = r_r.txbuf;
            r_nxt.hold_lzs  = wbyte[symseq_pkg::REQ_LZS];
            r_nxt.hold_del  = wbyte[symseq_pkg::REQ_DEL_LO +: 2];
            r_nxt.due       = 1'b1;
            r_nxt.due_code  = symseq_pkg::CNF_BUF_EMPTY;
          end
          if (r_r.sym_left == 4'h0 || sym_end)
          begin
            if (r_r.eop_sent)
            begin
              r_nxt.state   = symseq_pkg::ST_TX_CHECK;
              r_nxt.chk_cnt = 5'h00;
              r_nxt.sym_left = 4'h1;
            end
            else if (r_r.nbits != 4'h0)
            begin
              r_nxt.sym_left = r_r.bits[0] ? 4'h1 : 4'h2;
              r_nxt.crc      = crc_step(r_r.crc, r_r.bits[0]);
              r_nxt.bits     = {1'b0, r_r.bits[7:1]};
              r_nxt.nbits    = r_r.nbits - 4'h1;
            end
            else if (r_r.del == symseq_pkg::DEL_EOF
                     || r_r.del == symseq_pkg::DEL_EOP)
            begin
              r_nxt.sym_left = (r_r.del == symseq_pkg::DEL_EOP)
                             ? symseq_pkg::LEN_EOP
                             : symseq_pkg::LEN_EOF;
              r_nxt.eop_sent = (r_r.del == symseq_pkg::DEL_EOP);
              r_nxt.del      = symseq_pkg::DEL_NONE;
            end
            else if (r_r.hold_v)
            begin
              // A second packet end after one was sent is not repeated
              r_nxt.hold_v = 1'b0;
              r_nxt.bits   = r_r.hold_byte;
              r_nxt.nbits  = r_r.hold_lzs ? sig_len(r_r.hold_byte)
                                          : 4'h8;
              // None, field end or packet end; the extra code is ignored
              r_nxt.del    = (r_r.hold_del == 2'h3) ? symseq_pkg::DEL_NONE
                                                    : r_r.hold_del;
              r_nxt.sym_left = 4'h0;
            end
          end
        end
      end

      symseq_pkg::ST_TX_CHECK:
      begin
        if (req_wr && !wbyte[symseq_pkg::REQ_TX])
          r_nxt.state = symseq_pkg::ST_IDLE;
        else if (sym_end)
        begin
          r_nxt.chk_cnt = r_r.chk_cnt + 5'h01;
          r_nxt.crc     = {r_r.crc[14:0], 1'b0};
          if (r_r.chk_cnt == 5'(symseq_pkg::CHECK_BITS))
          begin
            r_nxt.state    = symseq_pkg::ST_TX_STAMP;
            r_nxt.stamp    = r_r.ts;
            r_nxt.rxbuf    = r_r.ts[7:0];
            r_nxt.byte_idx = 2'h1;
            r_nxt.due      = 1'b1;
            r_nxt.due_code = symseq_pkg::CNF_STAMP;
            r_nxt.sym_left = 4'h0;
          end
          else
            r_nxt.sym_left = 4'h1;
        end
      end

      default: r_nxt.state = symseq_pkg::ST_INIT;
    endcase

    // Medium drive follows the symbol being sent
    r_nxt.tx_en = r_nxt.state == symseq_pkg::ST_TX_PRE
                | r_nxt.state == symseq_pkg::ST_TX_BODY
                | r_nxt.state == symseq_pkg::ST_TX_CHECK;
    if (!r_nxt.tx_en)
      r_nxt.med = symseq_pkg::MED_INF;
    else if (r_r.state == symseq_pkg::ST_TX_PRE
             && r_nxt.state == symseq_pkg::ST_TX_PRE)
      r_nxt.med = r_nxt.pre_inf ? symseq_pkg::MED_INF : pkt_sup;
    else if (r_nxt.state == symseq_pkg::ST_TX_CHECK)
      r_nxt.med = r_nxt.crc[15] ? pkt_sup : other_sup(pkt_sup);
    // Every new body symbol starts with a transition, a one after a one too
    else if (r_r.state == symseq_pkg::ST_TX_BODY
             && (r_r.sym_left == 4'h0 || sym_end)
             && r_nxt.sym_left != 4'h0)
      r_nxt.med = other_sup(r_r.med);

    // Load waits a cycle after the confirm read so the line drops between
    if (r_nxt.due && !r_r.pend)
    begin
      r_nxt.pend = 1'b1;
      r_nxt.conf = r_nxt.due_code;
      r_nxt.due  = 1'b0;
    end

    // Soft restart overrides the state, drive, due and hold updates, not a confirm load
    if (req_wr && wbyte[symseq_pkg::REQ_RESTART])
    begin
      r_nxt.state  = symseq_pkg::ST_INIT;
      r_nxt.tx_en  = 1'b0;
      r_nxt.med    = symseq_pkg::MED_INF;
      r_nxt.due    = 1'b0;
      r_nxt.hold_v = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      r_r       <= '0;
      r_r.state <= symseq_pkg::ST_INIT;
    end
    else
      r_r <= r_nxt;
  end

  assign prdata_o  = r_r.prdata;
  assign pready_o  = r_r.pready;
  assign pslverr_o = r_r.pslverr;
  assign tx_med_o  = r_r.med;
  assign tx_en_o   = r_r.tx_en;
  assign hs_int_o  = r_r.pend;

endmodule

`default_nettype wire

// *** tb/symseq_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module symseq_checker (
  input wire logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o, pslverr_o, line_active_i, tx_en_o,
  input wire logic [1:0]  tx_med_o,
  input wire logic        hs_int_o
);
  wire logic done = psel_i && penable_i && pready_o;
  wire logic wrq  = done && pwrite_i && paddr_i == 8'h00;
  wire logic rdc  = done && !pwrite_i && paddr_i == 8'h04;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_hold; hs_int_o && !rdc |=> hs_int_o; endproperty
  a_hold: assert property (p_hold) else $error("irq fell early");
  property p_clr; rdc && hs_int_o |=> !hs_int_o; endproperty
  a_clr: assert property (p_clr) else $error("irq kept");
  property p_stop; wrq && !pwdata_i[7] |-> ##[1:3] !tx_en_o; endproperty
  a_stop: assert property (p_stop) else $error("tx kept on");
  property p_rst; wrq && pwdata_i[3] |-> ##[1:3] !tx_en_o; endproperty
  a_rst: assert property (p_rst) else $error("tx on after restart");
  // Sensing covers inferior symbols only; superior ones carry own energy
  property p_col; tx_en_o && line_active_i && tx_med_o == 2'h0
    |-> ##[1:3] !tx_en_o; endproperty
  a_col: assert property (p_col) else $error("no stop on collision");
  property p_ws; psel_i && !penable_i |=> !pready_o ##1 pready_o; endproperty
  a_ws: assert property (p_ws) else $error("wait state wrong");
  property p_one; pready_o |=> !pready_o; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_err; pslverr_o |-> pready_o; endproperty
  a_err: assert property (p_err) else $error("error without ready");
endmodule
bind powerline_symbol_sequencer symseq_checker u_symseq_checker (
  .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_med_o(tx_med_o),
  .line_active_i(line_active_i), .tx_en_o(tx_en_o), .hs_int_o(hs_int_o));
`default_nettype wire

// *** tb/line_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module line_model (
  input  wire logic       collide_i, carrier_i,
  output logic            line_active_o,
  output logic      [1:0] rx_med_o
);
  // Only commanded energy shows; a quiet line reads inferior, never stale
  assign line_active_o = collide_i;
  assign rx_med_o = carrier_i ? symseq_pkg::MED_SUP1 : symseq_pkg::MED_INF;
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d;
                         logic [9:0] x; logic e;} row_t;
  localparam row_t ROWS [6] = '{
    '{1'b0, 8'h10, 8'h0, 10'h1, 1'b0}, '{1'b0, 8'h14, 8'h0, 10'h0, 1'b1},
    '{1'b1, 8'h18, 8'hFF, 10'h0, 1'b1}, '{1'b1, 8'h08, 8'h5A, 10'h0, 1'b0},
    '{1'b1, 8'h00, 8'h0, 10'h0, 1'b0}, '{1'b0, 8'h10, 8'h0, 10'h2, 1'b0}};
  logic        clk_i = 1'b0, rstn_i = 1'b0, sel = 1'b0, en = 1'b0, wr = 1'b0;
  logic [7:0]  ad = 8'h00;
  logic [31:0] wd = 32'h0, rd, prd;
  // Line controls: 3 collide, 2 carrier, 1 preamble end, 0 body end
  logic [3:0]  ctl = 4'h0;
  logic        er, rdy, err, txen, hs, act;
  logic [1:0]  med, rxm;
  int          fail_count = 0, cmp_count = 0;
  always #2.5 clk_i = ~clk_i;
  powerline_symbol_sequencer #(.UST_CYC(16)) u_powerline_symbol_sequencer (
    .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(sel), .penable_i(en),
    .pwrite_i(wr), .paddr_i(ad), .pwdata_i(wd), .prdata_o(prd),
    .pready_o(rdy), .pslverr_o(err), .rx_med_i(rxm), .line_active_i(act),
    .rx_body_end_i(ctl[0]), .rx_crc_i(16'h0000), .rx_preamble_end_delimiter_i(ctl[1]),
    .rx_preamble_end_delimiter_noise_i(ctl[1]), .rx_pre_data_i(ctl[1]), .rx_pre_byte_i(8'h5A),
    .tx_med_o(med), .tx_en_o(txen), .hs_int_o(hs));
  line_model u_line_model (.collide_i(ctl[3]), .carrier_i(ctl[2]),
    .line_active_o(act), .rx_med_o(rxm));
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    cmp_count++;
    if (g !== x)
    begin
      fail_count++;
      $display("mismatch %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    sel <= 1'b1;
    wr  <= w;
    ad  <= a;
    wd  <= d;
    @(posedge clk_i);
    en  <= 1'b1;
    @(posedge clk_i);
    while (rdy !== 1'b1) @(posedge clk_i);
    rd = prd;
    er = err;
    sel <= 1'b0;
    en  <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic st(logic [31:0] x);
    apb(1'b0, 8'h10, 32'h0);
    chk("status", x, rd);
  endtask
  task automatic txw(logic [1:0] x);
    for (int n = 0; n < 200 && txen !== 1'b1; n++) @(posedge clk_i);
    // Enable rises one cycle ahead of the first symbol
    @(posedge clk_i);
    chk("tx_med", {30'h0, x}, {30'h0, med});
  endtask
  // Quiet or progress reports may queue ahead of the awaited code
  task automatic conf(logic [7:0] x, logic [7:0] m);
    for (int k = 0; k < 6; k++)
    begin
      while (hs !== 1'b1) @(posedge clk_i);
      apb(1'b0, 8'h04, 32'h0);
      if ((rd[7:0] & m) === x) break;
    end
    chk("confirm", {24'h0, x}, rd & {24'h0, m});
  endtask
  task automatic finish_test;
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge clk_i);
    fail_count++;
    finish_test;
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    foreach (ROWS[i])
    begin
      apb(ROWS[i].w, ROWS[i].a, {24'h0, ROWS[i].d});
      if (!ROWS[i].w) chk("read", {22'h0, ROWS[i].x}, rd);
      chk("slverr", {31'h0, ROWS[i].e}, {31'h0, er});
    end
    apb(1'b1, 8'h00, 32'hB6);
    txw(2'h2);
    conf(8'h10, 8'hFF);
    apb(1'b1, 8'h08, 32'h01);
    apb(1'b1, 8'h00, 32'hA4);
    conf(8'h10, 8'hFF);
    conf(8'hB4, 8'hFF);
    apb(1'b0, 8'h0C, 32'h0);
    chk("tx_stamp_lo", 32'h1, {31'h0, rd[7:0] != 8'h00});
    st(32'h100);
    apb(1'b1, 8'h00, 32'h0);
    st(32'h2);
    apb(1'b1, 8'h00, 32'hA6);
    txw(2'h1);
    ctl <= 4'hC;
    conf(8'hA0, 8'hFF);
    st(32'h4);
    ctl <= 4'h6;
    @(posedge clk_i);
    ctl <= 4'h4;
    conf(8'hF6, 8'hFF);
    ctl <= 4'h5;
    @(posedge clk_i);
    ctl <= 4'h4;
    st(32'h8);
    conf(8'hB4, 8'hF7);
    st(32'h10);
    apb(1'b0, 8'h0C, 32'h0);
    chk("rx_stamp_lo", 32'h1, {31'h0, rd[7:0] != 8'h00});
    apb(1'b1, 8'h00, 32'h01);
    conf(8'hB4, 8'hF7);
    apb(1'b0, 8'h0C, 32'h0);
    chk("rx_stamp_b1", 32'h0, rd);
    ctl <= 4'h0;
    apb(1'b1, 8'h00, 32'h20);
    st(32'h2);
    apb(1'b1, 8'h00, 32'hA6);
    txw(2'h2);
    apb(1'b1, 8'h00, 32'h0);
    st(32'h2);
    apb(1'b1, 8'h00, 32'h08);
    st(32'h1);
    finish_test;
  end
endmodule
`default_nettype wire
